// ===== rtl/lcdhp_port.sv
// lcdhp_port: host port, straps and display timing pins of the lcd driver.
// assumes a classic wishbone master on ref_clk; pins arrive asynchronously.
//
// Chosen here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module lcdhp_port #(
	parameter int TICK_HALF = lcdhp_pkg::TICK_HALF_DEF,
	parameter int AC_TICKS  = lcdhp_pkg::AC_TICKS_DEF
) (
	input  wire logic                   ref_clk,
	input  wire logic                   rst_n,
	input  wire lcdhp_pkg::lcdhp_pins_s pins_i,
	input  wire lcdhp_pkg::lcdhp_wbreq_s wb_i,
	output var  logic [31:0]            dat_o,
	output var  logic                   ack_o,
	output var  logic [7:0]             data_out,
	output var  logic [7:0]             data_oe_n,
	output var  logic                   tick_out,
	output var  logic                   tick_oe_n,
	output var  logic                   ac_out,
	output var  logic                   ac_oe_n,
	output var  logic                   blank_out_n,
	output var  logic                   blank_oe_n,
	output var  logic                   static_drive_out,
	output var  logic                   osc_enable,
	output var  logic                   power_enable,
	output var  logic                   v5_internal,
	output var  logic                   high_power
);
	import lcdhp_pkg::*;

	localparam int DW = $clog2(TICK_HALF + 1);
	localparam int AW = $clog2(AC_TICKS + 1);

	function automatic logic rise(input logic now, input logic prev);
		return now & ~prev;
	endfunction : rise

	lcdhp_pins_s s1_q, s2_q, s3_q;
	logic [7:0]  shreg_q, rx_q, tx_data_q, tx_stat_q;
	logic [2:0]  cnt_q;
	logic        rx_dc_q, rx_valid_q;
	logic [1:0]  ctrl_q;
	logic [DW-1:0] div_q;
	logic [AW-1:0] acc_q;
	logic        tick_q, ac_q;

	// pin synchronisers; the third stage only feeds edge detection
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= pins_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	logic init, sel, par, estyle, master, osc_int;
	logic sep_wr, en_wr, ser_clk, ser_evt, par_evt, drive, rd_rx, wb_go;
	logic [7:0] ser_byte;
	assign init    = !s2_q.initialize_n;
	assign sel     = !s2_q.chip_select_low && s2_q.chip_select_high;
	assign par     = s2_q.link_select;
	assign estyle  = s2_q.bus_style_select;
	assign master  = s2_q.primary_role_select;
	assign osc_int = master && s2_q.osc_source_select;
	// host is trusted not to raise both strobes at once in separate style
	assign sep_wr  = !estyle && rise(s2_q.wr_pin, s3_q.wr_pin);
	assign en_wr   = estyle && !s2_q.wr_pin && rise(s3_q.rd_pin, s2_q.rd_pin);
	assign par_evt = sel && par && (sep_wr || en_wr);
	assign ser_clk = sel && !par && rise(s2_q.data[6], s3_q.data[6]);
	assign ser_evt = ser_clk && cnt_q == 3'd7;
	assign ser_byte = {shreg_q[6:0], s2_q.data[7]};
	assign drive   = sel && par && s2_q.wr_pin &&
		(estyle ? s2_q.rd_pin : !s2_q.rd_pin);
	assign wb_go   = wb_i.cyc && wb_i.stb && !ack_o;
	assign rd_rx   = wb_go && !wb_i.we && wb_i.adr == ADR_RX;

	// serial shift path, msb first; cleared whenever the chip is not active
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			shreg_q <= 8'h00;
			cnt_q   <= 3'd0;
		end else if (init || !sel || par) begin
			shreg_q <= 8'h00;
			cnt_q   <= 3'd0;
		end else if (ser_clk) begin
			shreg_q <= ser_byte;
			cnt_q   <= cnt_q + 3'd1;
		end
	end

	// received byte; a new byte beats a read that clears valid
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_q       <= 8'h00;
			rx_dc_q    <= 1'b0;
			rx_valid_q <= 1'b0;
		end else if (init) begin
			rx_q       <= 8'h00;
			rx_dc_q    <= 1'b0;
			rx_valid_q <= 1'b0;
		end else if (ser_evt) begin
			rx_q       <= ser_byte;
			rx_dc_q    <= s2_q.data_or_command;
			rx_valid_q <= 1'b1;
		end else if (par_evt) begin
			rx_q       <= s2_q.data;
			rx_dc_q    <= s2_q.data_or_command;
			rx_valid_q <= 1'b1;
		end else if (rd_rx) begin
			rx_valid_q <= 1'b0;
		end
	end

	// host read path: display data or status by data_or_command
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			data_out  <= 8'h00;
			data_oe_n <= 8'hFF;
		end else begin
			data_out  <= s2_q.data_or_command ? tx_data_q : tx_stat_q;
			// serial mode and deselect never drive, so D0-D5 float too
			data_oe_n <= (drive && !init) ? 8'h00 : 8'hFF;
		end
	end

	// wishbone slave: one wait state, byte lane 0 carries writes
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= wb_go;
			dat_o <= 32'h0000_0000;
			if (wb_go && !wb_i.we) begin
				unique case (wb_i.adr)
					ADR_RX:     dat_o <= {22'h0, rx_valid_q, rx_dc_q, rx_q};
					ADR_CTRL:   dat_o <= {30'h0, ctrl_q};
					ADR_TXDATA: dat_o <= {24'h0, tx_data_q};
					ADR_TXSTAT: dat_o <= {24'h0, tx_stat_q};
					ADR_STAT:   dat_o <= {20'h0, cnt_q, s2_q.blank_in, s2_q.ac_in,
						s2_q.tick_in, s2_q.link_select, s2_q.bus_style_select,
						s2_q.osc_source_select, master, s2_q.v5_divider_select,
						s2_q.supply_power_level};
					default:    dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q    <= CTRL_RST;
			tx_data_q <= TX_RST;
			tx_stat_q <= TX_RST;
		end else if (init) begin
			ctrl_q    <= CTRL_RST;
			tx_data_q <= TX_RST;
			tx_stat_q <= TX_RST;
		end else if (wb_go && wb_i.we && wb_i.sel[0]) begin
			if (wb_i.adr == ADR_CTRL) ctrl_q <= wb_i.dat[1:0];
			if (wb_i.adr == ADR_TXDATA) tx_data_q <= wb_i.dat[7:0];
			if (wb_i.adr == ADR_TXSTAT) tx_stat_q <= wb_i.dat[7:0];
		end
	end

	// display timing: own divider, external tick, or follow the master
	logic tick_evt;
	assign tick_evt = osc_int ? (div_q == DW'(TICK_HALF - 1) && !tick_q)
		: rise(s2_q.tick_in, s3_q.tick_in);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q  <= '0;
			tick_q <= 1'b0;
		end else if (init || !osc_int) begin
			div_q  <= '0;
			tick_q <= 1'b0;
		end else if (div_q == DW'(TICK_HALF - 1)) begin
			div_q  <= '0;
			tick_q <= !tick_q;
		end else begin
			div_q  <= div_q + 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_q <= '0;
			ac_q  <= 1'b0;
		end else if (init || !master) begin
			acc_q <= '0;
			ac_q  <= 1'b0;
		end else if (tick_evt) begin
			if (acc_q == AW'(AC_TICKS - 1)) begin
				acc_q <= '0;
				ac_q  <= !ac_q;
			end else begin
				acc_q <= acc_q + 1'b1;
			end
		end
	end

	logic phase;
	assign phase = master ? ac_q : s2_q.ac_in;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_out         <= 1'b0;
			tick_oe_n        <= 1'b1;
			ac_out           <= 1'b0;
			ac_oe_n          <= 1'b1;
			blank_out_n      <= 1'b0;
			blank_oe_n       <= 1'b1;
			static_drive_out <= 1'b0;
			osc_enable       <= 1'b0;
			power_enable     <= 1'b0;
			v5_internal      <= 1'b0;
			high_power       <= 1'b0;
		end else begin
			tick_out         <= tick_q;
			tick_oe_n        <= !osc_int;
			ac_out           <= ac_q;
			ac_oe_n          <= !master;
			blank_out_n      <= ctrl_q[CTRL_DISP_ON];
			blank_oe_n       <= !master;
			static_drive_out <= master && ctrl_q[CTRL_STATIC] && phase;
			osc_enable       <= osc_int;
			power_enable     <= master;
			v5_internal      <= master && s2_q.v5_divider_select;
			high_power       <= master && !s2_q.supply_power_level;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_unsel_float;
		!sel |=> data_oe_n == 8'hFF;
	endproperty
	a_unsel_float: assert property (p_unsel_float) else $error("bus driven while deselected");

	property p_serial_noread;
		!par |=> data_oe_n == 8'hFF;
	endproperty
	a_serial_noread: assert property (p_serial_noread) else $error("bus driven in serial");

	property p_sep_read;
		sel && par && !estyle && !init && !s2_q.rd_pin && s2_q.wr_pin |=> data_oe_n == 8'h00;
	endproperty
	a_sep_read: assert property (p_sep_read) else $error("separate read not driven");

	property p_en_read;
		sel && par && estyle && !init && s2_q.rd_pin && s2_q.wr_pin |=> data_oe_n == 8'h00;
	endproperty
	a_en_read: assert property (p_en_read) else $error("enable read not driven");

	property p_wr_capture;
		par_evt && sep_wr && !init |=> rx_q == $past(s2_q.data) && rx_valid_q;
	endproperty
	a_wr_capture: assert property (p_wr_capture) else $error("write byte lost");

	property p_ser_byte;
		ser_evt && !init |=> rx_q == $past(ser_byte) && rx_dc_q == $past(s2_q.data_or_command);
	endproperty
	a_ser_byte: assert property (p_ser_byte) else $error("serial byte wrong");

	property p_unsel_clear;
		!sel ##1 !sel |-> cnt_q == 3'd0 && shreg_q == 8'h00;
	endproperty
	a_unsel_clear: assert property (p_unsel_clear) else $error("shift not cleared");

	property p_select_only;
		$rose(rx_valid_q) |-> $past(sel);
	endproperty
	a_select_only: assert property (p_select_only) else $error("byte taken unselected");

	property p_init_hold;
		init |=> ctrl_q == CTRL_RST && !rx_valid_q;
	endproperty
	a_init_hold: assert property (p_init_hold) else $error("settings not initialised");

	property p_slave_pins;
		!master |=> tick_oe_n && ac_oe_n && blank_oe_n && !osc_enable && !power_enable;
	endproperty
	a_slave_pins: assert property (p_slave_pins) else $error("slave drives timing");

	property p_static;
		static_drive_out |-> $past(master) && $past(ctrl_q[CTRL_STATIC]);
	endproperty
	a_static: assert property (p_static) else $error("static drive misused");

	property p_straps;
		!master |=> !v5_internal && !high_power;
	endproperty
	a_straps: assert property (p_straps) else $error("strap honoured as slave");
endmodule : lcdhp_port
`default_nettype wire

// ===== inc/lcdhp_pkg.sv
// lcdhp_pkg: constants and carriers for the lcd driver host port block.
// assumes one 100 MHz clock domain; every pin is synchronised inside the block.
// Behaviour
// - link_select high parallel, low serial
// - serial: D7 data, D6 clock, rest floating
// - unselected chip floats all data lines
// - data_or_command high data, low control
// - initialize_n low holds settings at initial values
// - transfers only when both selects active
// - separate style: drive bus while read_strobe_n low
// - enable style: read pin is active-high enable
// - separate style: capture on store_strobe_n rise
// - enable style: write pin is direction
// - bus_style_select high enable, low separate
// - osc_source_select high enables internal oscillator
// - primary_role_select high generates timing, low follows
// - role and source set oscillator, power, pin directions
// - ac_phase_pin output master, input slave
// - blanking_n output master, input slave
// - static drive only master with indicator on
// - v5 divider strap honoured only as master
// - power level strap honoured only as master
// - serial msb first, byte on eighth edge
// - data_or_command sampled at every eighth edge
// - deselect clears shift register and counter
// - no read path in serial mode
package lcdhp_pkg;
	localparam logic [7:0] ADR_RX     = 8'h00;
	localparam logic [7:0] ADR_CTRL   = 8'h04;
	localparam logic [7:0] ADR_TXDATA = 8'h08;
	localparam logic [7:0] ADR_TXSTAT = 8'h0C;
	localparam logic [7:0] ADR_STAT   = 8'h10;
	localparam int RX_DC_BIT    = 8;
	localparam int RX_VALID_BIT = 9;
	localparam int CTRL_STATIC  = 0;
	localparam int CTRL_DISP_ON = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [7:0] TX_RST   = 8'h00;
	localparam int TICK_HALF_DEF = 32;
	localparam int AC_TICKS_DEF  = 16;

	typedef struct packed {
		logic [7:0] data;
		logic       chip_select_low;
		logic       chip_select_high;
		logic       data_or_command;
		logic       rd_pin;
		logic       wr_pin;
		logic       link_select;
		logic       bus_style_select;
		logic       osc_source_select;
		logic       primary_role_select;
		logic       v5_divider_select;
		logic       supply_power_level;
		logic       initialize_n;
		logic       tick_in;
		logic       ac_in;
		logic       blank_in;
	} lcdhp_pins_s;

	typedef struct packed {
		logic [7:0] adr;
		logic [31:0] dat;
		logic [3:0] sel;
		logic       we;
		logic       cyc;
		logic       stb;
	} lcdhp_wbreq_s;
endpackage : lcdhp_pkg

// ===== verif/lcdhp_host.sv
// lcdhp_host: host microprocessor model on the lcd driver pins.
// assumes its tasks are called right after a rising ref_clk edge.
`timescale 1ns/1ns
`default_nettype none
module lcdhp_host (
	input  wire logic                   ref_clk,
	input  wire logic [7:0]             data_out,
	input  wire logic [7:0]             data_oe_n,
	output var  lcdhp_pkg::lcdhp_pins_s pins
);
	import lcdhp_pkg::*;
	// deselected, separate strobes idle, master with internal osc
	initial pins = 23'h0_6CF8;
	task automatic cfg(input logic [6:0] c);
		pins[9:3] <= c;
		repeat (6) @(posedge ref_clk);
	endtask : cfg
	// cs carries {chip_select_high, chip_select_low}; 2'b10 selects the chip
	task automatic par_wr(input logic sty, input logic [1:0] cs, input logic dc,
		input logic [7:0] b);
		pins.data             <= b;
		pins.data_or_command  <= dc;
		pins.chip_select_high <= cs[1];
		pins.chip_select_low  <= cs[0];
		pins.wr_pin          <= 1'b0;
		pins.rd_pin          <= 1'b1;
		repeat (6) @(posedge ref_clk);
		if (sty) begin
			pins.rd_pin <= 1'b0;
		end else begin
			pins.wr_pin <= 1'b1;
		end
		repeat (6) @(posedge ref_clk);
		pins.chip_select_low  <= 1'b1;
		pins.chip_select_high <= 1'b1;
		// released bus shows no stale value
		pins.data            <= ~b;
		pins.wr_pin          <= 1'b1;
		pins.rd_pin          <= ~sty;
		repeat (2) @(posedge ref_clk);
	endtask : par_wr
	// sty low: read strobe low; sty high: enable high with direction high
	task automatic par_rd(input logic sty, input logic dc, output logic [7:0] v,
		output logic [7:0] oe);
		pins.data            <= ~pins.data;
		pins.data_or_command <= dc;
		pins.chip_select_low <= 1'b0;
		pins.wr_pin          <= 1'b1;
		pins.rd_pin          <= sty;
		repeat (6) @(posedge ref_clk);
		v  = data_out;
		oe = data_oe_n;
		pins.rd_pin          <= ~sty;
		pins.chip_select_low <= 1'b1;
		repeat (4) @(posedge ref_clk);
	endtask : par_rd
	task automatic ser_wr(input logic dc, input logic [7:0] b, input int n);
		pins.data_or_command <= dc;
		pins.chip_select_low <= 1'b0;
		pins.data[6]         <= 1'b0;
		for (int i = 7; i > 7 - n; i--) begin
			pins.data[7] <= b[i];
			repeat (8) @(posedge ref_clk);
			pins.data[6] <= 1'b1;
			repeat (8) @(posedge ref_clk);
			pins.data[6] <= 1'b0;
		end
		repeat (8) @(posedge ref_clk);
		pins.chip_select_low <= 1'b1;
		pins.data[7]         <= ~pins.data[7];
		repeat (4) @(posedge ref_clk);
	endtask : ser_wr
	// t carries {tick_in, ac_in, blank_in}
	task automatic timing(input logic [2:0] t);
		{pins.tick_in, pins.ac_in, pins.blank_in} <= t;
		repeat (6) @(posedge ref_clk);
	endtask : timing
endmodule : lcdhp_host
`default_nettype wire

// ===== verif/testbench.sv
// testbench: host port checks through the host model and wishbone.
// assumes short display timing parameters on lcdhp_port.
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import lcdhp_pkg::*;
	logic         ref_clk = 1'b0;
	logic         rst_n   = 1'b0;
	lcdhp_wbreq_s wb_q    = '0;
	lcdhp_pins_s  pins;
	logic [31:0]  dat_o;
	logic [31:0]  q;
	logic [31:0]  lfsr    = 32'h0000_7752;
	logic [7:0]   data_out, data_oe_n, v, oe, t1, t2;
	logic         ack_o, tick_out, tick_oe_n, ac_out, ac_oe_n, blank_out_n, blank_oe_n;
	logic         static_drive_out, osc_enable, power_enable, v5_internal, high_power, a0;
	int           fails = 0;
	int           tests_run = 0;
	int           last = 0;
	int           exp_q[$];
	always #5 ref_clk = ~ref_clk;
	lcdhp_host host_inst (.ref_clk(ref_clk), .data_out(data_out), .data_oe_n(data_oe_n),
		.pins(pins));
	lcdhp_port #(.TICK_HALF(2), .AC_TICKS(2)) lcdhp_port_inst (.ref_clk(ref_clk),
		.rst_n(rst_n), .pins_i(pins), .wb_i(wb_q), .dat_o(dat_o), .ack_o(ack_o),
		.data_out(data_out), .data_oe_n(data_oe_n), .tick_out(tick_out),
		.tick_oe_n(tick_oe_n), .ac_out(ac_out), .ac_oe_n(ac_oe_n), .blank_out_n(blank_out_n),
		.blank_oe_n(blank_oe_n), .static_drive_out(static_drive_out),
		.osc_enable(osc_enable), .power_enable(power_enable), .v5_internal(v5_internal),
		.high_power(high_power));
	function automatic logic [7:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr[7:0];
	endfunction : rnd
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		// no cycle limit here: a missing ack is caught by the watchdog
		wb_q <= '{adr: a, dat: d, sel: 4'hF, we: we, cyc: 1'b1, stb: 1'b1};
		do begin
			@(posedge ref_clk);
		end while (ack_o !== 1'b1);
		q = dat_o;
		wb_q.cyc <= 1'b0;
		wb_q.stb <= 1'b0;
		@(posedge ref_clk);
	endtask : wb
	task automatic rx_chk();
		int e;
		e = exp_q.pop_front();
		wb(1'b0, ADR_RX, 32'h0);
		chk("rx", e, q);
		wb(1'b0, ADR_RX, 32'h0);
		// a read clears valid only
		last = e & 32'h0000_01FF;
		chk("rx_clear", last, q);
	endtask : rx_chk
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : test_done
	initial begin
		#200000;
		fails++;
		test_done();
	end
	initial begin
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		wb(1'b0, ADR_CTRL, 32'h0);
		chk("ctrl_rst", 32'h0, q);
		wb(1'b1, 8'h14, 32'hFFFF_FFFF);
		wb(1'b0, 8'h14, 32'h0);
		chk("unmapped", 32'h0, q);
		wb(1'b1, ADR_CTRL, 32'hFFFF_FFFF);
		wb(1'b0, ADR_CTRL, 32'h0);
		chk("ctrl", 32'h3, q);
		$display("test regs done");
		for (int i = 0; i < 4; i++) begin
			v = rnd();
			host_inst.cfg({1'b1, i[1], 5'h1F});
			host_inst.par_wr(i[1], 2'b10, i[0], v);
			exp_q.push_back({22'h0, 1'b1, i[0], v});
			rx_chk();
		end
		host_inst.cfg(7'h5F);
		host_inst.par_wr(1'b0, 2'b11, 1'b1, 8'h5A);
		wb(1'b0, ADR_RX, 32'h0);
		chk("rx_unsel", last, q);
		host_inst.par_wr(1'b0, 2'b00, 1'b0, 8'hA5);
		wb(1'b0, ADR_RX, 32'h0);
		chk("rx_unsel_high", last, q);
		chk("oe_unsel", 8'hFF, data_oe_n);
		t1 = rnd();
		t2 = rnd();
		wb(1'b1, ADR_TXDATA, {24'h0, t1});
		wb(1'b1, ADR_TXSTAT, {24'h0, t2});
		host_inst.par_rd(1'b0, 1'b1, v, oe);
		chk("rd_data", {8'h00, t1}, {oe, v});
		host_inst.par_rd(1'b0, 1'b0, v, oe);
		chk("rd_stat", {8'h00, t2}, {oe, v});
		host_inst.cfg(7'h7F);
		host_inst.par_rd(1'b1, 1'b1, v, oe);
		chk("rd_en", {8'h00, t1}, {oe, v});
		$display("test parallel done");
		host_inst.cfg(7'h1F);
		host_inst.ser_wr(1'b1, rnd(), 3);
		wb(1'b0, ADR_STAT, 32'h0);
		chk("ser_cnt", 3'h0, q[11:9]);
		chk("stat", 6'h0F, q[5:0]);
		for (int i = 0; i < 2; i++) begin
			v = rnd();
			host_inst.ser_wr(i[0], v, 8);
			exp_q.push_back({22'h0, 1'b1, i[0], v});
			rx_chk();
		end
		host_inst.par_rd(1'b0, 1'b1, v, oe);
		chk("ser_noread", 8'hFF, oe);
		$display("test serial done");
		wb(1'b1, ADR_CTRL, 32'h1);
		for (int i = 0; i < 8; i++) begin
			host_inst.cfg({2'b10, i[1], i[0], i[2] ^ i[1], i[2], 1'b1});
			chk("straps", {!(i[0] & i[1]), !i[0], !i[0], i[0] & i[1], i[0],
				i[0] & (i[2] ^ i[1]), i[0] & !i[2]}, {tick_oe_n, ac_oe_n, blank_oe_n,
				osc_enable, power_enable, v5_internal, high_power});
			chk("static", i[0] ? ac_out : 1'b0, static_drive_out);
		end
		// own divider: tick_out flips every two clocks with the bench parameters
		a0 = tick_out;
		repeat (2) @(posedge ref_clk);
		chk("tick", !a0, tick_out);
		host_inst.cfg(7'h4B);
		host_inst.timing(3'b000);
		a0 = ac_out;
		host_inst.timing(3'b100);
		host_inst.timing(3'b000);
		host_inst.timing(3'b111);
		chk("ac_ext", !a0, ac_out);
		wb(1'b0, ADR_STAT, 32'h0);
		chk("stat_in", 3'h7, q[8:6]);
		$display("test roles done");
		wb(1'b1, ADR_CTRL, 32'h3);
		chk("blank", 1'b1, blank_out_n);
		host_inst.cfg(7'h5E);
		wb(1'b0, ADR_CTRL, 32'h0);
		chk("ctrl_init", 32'h0, q);
		host_inst.cfg(7'h5F);
		wb(1'b0, ADR_CTRL, 32'h0);
		chk("ctrl_after", 32'h0, q);
		$display("test init done");
		test_done();
	end
endmodule : testbench
`default_nettype wire
